//--- design/iwb_frame_buf.sv
`timescale 1ns/1ns
module iwb_frame_buf #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4096
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  // Fill side
  input  wire logic             push_in,
  input  wire logic [WIDTH-1:0] push_data_in,
  output logic                  full_out,
  // Drain side
  input  wire logic             pop_in,
  output logic [WIDTH-1:0]      pop_data_out,
  output logic                  empty_out
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   count;
  } iwb_buf_state_t;

  iwb_buf_state_t q;
  iwb_buf_state_t d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_push;
  logic             do_pop;

  // ***************************************************************
  // Pointer bookkeeping
  // ***************************************************************
  // Pushes on a full buffer are refused rather than overwriting
  assign do_push      = push_in && !full_out;
  assign do_pop       = pop_in && !empty_out;
  assign full_out     = (q.count == (AW+1)'(DEPTH));
  assign empty_out    = (q.count == '0);
  assign pop_data_out = mem[q.rptr];

  always_comb begin
    d = q;
    if (do_push) begin
      d.wptr = (q.wptr == AW'(DEPTH-1)) ? '0 : q.wptr + 1'b1;
    end
    if (do_pop) begin
      d.rptr = (q.rptr == AW'(DEPTH-1)) ? '0 : q.rptr + 1'b1;
    end
    d.count = q.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage has no reset, it only holds pixel data
  always_ff @(posedge mclk_in) begin
    if (do_push) begin
      mem[q.wptr] <= push_data_in;
    end
  end

endmodule // iwb_frame_buf

//--- design/iwb_image_ctrl.sv
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ns
// Summary of operation
// RULE1 - Buffer readout; send only once overrun and underrun are avoided.
// RULE2 - Readout time is height times 52.55 us plus mono or colour constant.
// RULE3 - Transmission time is packets per frame times one 125 us bus cycle.
// RULE4 - If sending outlasts readout, start it 125 us after readout starts.
// RULE5 - Otherwise delay start by readout minus transmission plus 125 us.
// RULE6 - Gain accepts 350 to 1023 and drives the analog gain stage.
// RULE7 - Gain 350 means unity amplification into the converter.
// RULE8 - Software keeps gain within 350 to 511 in 16-bit modes.
// RULE9 - Brightness accepts 0 to 255 and sets the pixel offset.
// RULE10 - In 8-bit and YUV modes every 16 brightness steps add one.
// RULE11 - In 16-bit modes each brightness step adds one, 16 giving one.
// RULE12 - Coordinates count from top-left sensor corner, column 0 row 0.
// RULE13 - Only pixels inside the rectangle are sent; others are dropped.
// RULE14 - Monochrome units use the region only in format 7 mode 0.
// RULE15 - Colour units use it in format 7 mode 0 or 1; mode 1 colour only.
// RULE16 - Per-mode position and size registers; the selected mode's apply.
// RULE17 - Full sensor is 0,0,1624 by 1236 rows, colour 1234 rows.
// RULE18 - Software keeps left plus width at most 1624.
// RULE19 - Software keeps top plus height within 1236 mono or 1234 colour.
// RULE20 - Colour units need even width, height, left and top.
// RULE21 - Only region position may change while capture runs; size is frozen.
// RULE22 - Settings are latched at each frame start so frames never mix them.
module iwb_image_ctrl
  import iwb_pkg::*;
#(
  parameter bit          COLOR_UNIT  = 1'b0,
  parameter int unsigned PIX_W       = 16,
  parameter int unsigned BUF_DEPTH   = 4096,
  parameter int unsigned ROW_U       = iwb_pkg::ROW_UNITS,
  parameter int unsigned MONO_C_U    = iwb_pkg::MONO_C_UNITS,
  parameter int unsigned COLOR_C_U   = iwb_pkg::COLOR_C_UNITS,
  parameter int unsigned CYCLE_U     = iwb_pkg::CYCLE_UNITS
) (
  // Clock, reset and enable
  input  wire logic                        mclk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        ce_in,
  // Register port
  input  wire logic [iwb_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [iwb_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic [iwb_pkg::DATA_W-1:0]       reg_rdata_out,
  // Sensor readout stream
  input  wire logic                        pix_frame_start_in,
  input  wire logic                        pix_valid_in,
  input  wire logic [PIX_W-1:0]            pix_data_in,
  // Analog gain stage
  output logic [iwb_pkg::GAIN_W-1:0]       gain_setting_code_out,
  // Isochronous transmit path
  output logic                             tx_frame_start_out,
  output logic                             tx_valid_out,
  output logic [PIX_W-1:0]                 tx_data_out,
  input  wire logic                        tx_ready_in
);

  localparam logic [10:0] SENSOR_ROWS = COLOR_UNIT ? ROWS_COLOR : ROWS_MONO;
  localparam int unsigned C_U         = COLOR_UNIT ? COLOR_C_U : MONO_C_U;

  typedef struct packed {
    logic                capture;
    logic                wide;
    logic [2:0]          fmt;
    logic [2:0]          mode;
    logic [GAIN_W-1:0]   gain;
    logic [BRIGHT_W-1:0] bright;
    logic [10:0]         left0;
    logic [10:0]         top0;
    logic [10:0]         width0;
    logic [10:0]         height0;
    logic [10:0]         left1;
    logic [10:0]         top1;
    logic [10:0]         width1;
    logic [10:0]         height1;
    logic [PKTS_W-1:0]   pkts;
    logic [10:0]         f_left;
    logic [10:0]         f_top;
    logic [10:0]         f_width;
    logic [10:0]         f_height;
    logic [GAIN_W-1:0]   f_gain;
    logic [BRIGHT_W-1:0] f_offset;
    logic                f_wide;
    logic [10:0]         col;
    logic [10:0]         row;
    logic [31:0]         rd_units;
    logic [31:0]         delay_units;
    logic [31:0]         timer;
    logic                waiting;
    logic                sending;
    logic [21:0]         remaining;
    logic                overrun;
    logic                tx_start;
    logic                out_valid;
    logic [PIX_W-1:0]    out_data;
    logic [DATA_W-1:0]   rdata;
  } iwb_state_t;

  iwb_state_t q;
  iwb_state_t d;

  logic             region_on;
  logic [10:0]      sel_left;
  logic [10:0]      sel_top;
  logic [10:0]      sel_width;
  logic [10:0]      sel_height;
  logic [31:0]      rd_calc;
  logic [31:0]      tx_calc;
  logic [31:0]      delay_calc;
  logic [BRIGHT_W-1:0] offset_calc;
  logic             in_window;
  logic [PIX_W:0]   pix_sum;
  logic [PIX_W-1:0] pix_out;
  logic [PIX_W-1:0] pix_max;
  logic             buf_push;
  logic             buf_pop;
  logic             buf_full;
  logic             buf_empty;
  logic [PIX_W-1:0] buf_data;
  logic [DATA_W-1:0] rd_mux;

  // ***************************************************************
  // Region selection and frame timing figures
  // ***************************************************************
  // Mode 1 is only honoured on colour units
  assign region_on = (q.fmt == FMT_REGION) && ((q.mode == MODE_0) ||
                     (COLOR_UNIT && (q.mode == MODE_1))); // RULE14 RULE15
  always_comb begin
    if (!region_on) begin
      sel_left   = '0; // RULE17
      sel_top    = '0;
      sel_width  = SENSOR_COLS;
      sel_height = SENSOR_ROWS;
    end else if (q.mode == MODE_1) begin
      sel_left   = q.left1; // RULE16
      sel_top    = q.top1;
      sel_width  = q.width1;
      sel_height = q.height1;
    end else begin
      sel_left   = q.left0; // RULE16
      sel_top    = q.top0;
      sel_width  = q.width0;
      sel_height = q.height0;
    end
  end

  // Readout and transmission times in 10 ns units
  assign rd_calc = 32'(sel_height * ROW_U) + 32'(C_U); // RULE2
  assign tx_calc = 32'(q.pkts * CYCLE_U); // RULE3
  // Equal times fall to the second case, which also yields one cycle
  assign delay_calc = (tx_calc > rd_calc) ? 32'(CYCLE_U) // RULE4
                    : rd_calc - tx_calc + 32'(CYCLE_U); // RULE5

  // Offset scale depends on the output width
  always_comb begin
    if (q.wide) begin
      offset_calc = (q.bright > BRIGHT_WIDE_BIAS) ?
                    q.bright - BRIGHT_WIDE_BIAS : '0; // RULE11
    end else begin
      offset_calc = q.bright >> BRIGHT_SHIFT; // RULE10
    end
  end

  // ***************************************************************
  // Pixel window and offset
  // ***************************************************************
  // Counters start at the top-left corner of the array
  assign in_window = (q.col >= q.f_left) && // RULE12 RULE13
                     ({1'b0, q.col} < {1'b0, q.f_left} + {1'b0, q.f_width}) &&
                     (q.row >= q.f_top) &&
                     ({1'b0, q.row} < {1'b0, q.f_top} + {1'b0, q.f_height});
  // Narrow modes saturate at the 8-bit ceiling
  assign pix_max = q.f_wide ? '1 : PIX_W'(8'hFF);
  assign pix_sum = {1'b0, pix_data_in} + (PIX_W+1)'(q.f_offset); // RULE9
  assign pix_out = (pix_sum > {1'b0, pix_max}) ? pix_max : pix_sum[PIX_W-1:0];
  // Pixels that find the buffer full are lost and flagged
  assign buf_push = ce_in && pix_valid_in && in_window; // RULE1
  assign buf_pop  = ce_in && q.sending && !buf_empty &&
                    (!q.out_valid || tx_ready_in); // RULE1

  // ***************************************************************
  // Register read mux
  // ***************************************************************
  always_comb begin
    rd_mux = '0;
    case (reg_addr_in)
      REG_CTRL:   rd_mux = DATA_W'({q.wide, q.capture});
      REG_VIDEO:  rd_mux = DATA_W'({q.fmt, 5'h00, q.mode});
      REG_GAIN:   rd_mux = DATA_W'(q.gain);
      REG_BRIGHT: rd_mux = DATA_W'(q.bright);
      REG_POS0:   rd_mux = {5'h00, q.top0, 5'h00, q.left0};
      REG_SIZE0:  rd_mux = {5'h00, q.height0, 5'h00, q.width0};
      REG_POS1:   rd_mux = {5'h00, q.top1, 5'h00, q.left1};
      REG_SIZE1:  rd_mux = {5'h00, q.height1, 5'h00, q.width1};
      REG_PKTS:   rd_mux = DATA_W'(q.pkts);
      REG_STATUS: rd_mux = DATA_W'({q.sending, q.waiting, q.overrun});
      REG_RDTIME: rd_mux = q.rd_units;
      REG_DELAY:  rd_mux = q.delay_units;
      default:    rd_mux = '0;
    endcase
  end

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    d          = q;
    d.tx_start = 1'b0;
    d.rdata    = reg_rd_in ? rd_mux : '0;

    // Register writes; size is frozen while capture runs
    if (reg_wr_in) begin
      case (reg_addr_in)
        REG_CTRL: begin
          d.capture = reg_wdata_in[CTRL_CAPTURE_BIT];
          d.wide    = reg_wdata_in[CTRL_WIDE_BIT];
        end
        REG_VIDEO: begin
          d.fmt  = reg_wdata_in[VID_FMT_LSB +: VID_FIELD_W];
          d.mode = reg_wdata_in[VID_MODE_LSB +: VID_FIELD_W];
        end
        REG_GAIN: begin
          // Codes below unity gain are raised to it
          d.gain = (reg_wdata_in[GAIN_W-1:0] < GAIN_MIN) ? GAIN_MIN
                   : reg_wdata_in[GAIN_W-1:0]; // RULE6 RULE7
        end
        REG_BRIGHT: d.bright = reg_wdata_in[BRIGHT_W-1:0]; // RULE9
        REG_POS0: begin
          d.left0 = reg_wdata_in[POS_LEFT_LSB +: COORD_W];
          d.top0  = reg_wdata_in[POS_TOP_LSB +: COORD_W];
        end
        REG_SIZE0: begin
          if (!q.capture) begin // RULE21
            d.width0  = reg_wdata_in[SIZE_WIDTH_LSB +: COORD_W];
            d.height0 = reg_wdata_in[SIZE_HEIGHT_LSB +: COORD_W];
          end
        end
        REG_POS1: begin
          d.left1 = reg_wdata_in[POS_LEFT_LSB +: COORD_W];
          d.top1  = reg_wdata_in[POS_TOP_LSB +: COORD_W];
        end
        REG_SIZE1: begin
          if (!q.capture) begin // RULE21
            d.width1  = reg_wdata_in[SIZE_WIDTH_LSB +: COORD_W];
            d.height1 = reg_wdata_in[SIZE_HEIGHT_LSB +: COORD_W];
          end
        end
        REG_PKTS: d.pkts = reg_wdata_in[PKTS_W-1:0];
        REG_STATUS: begin
          // Write one to clear; a new overrun in the same cycle wins
          if (reg_wdata_in[STAT_OVERRUN_BIT]) begin
            d.overrun = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Frame start latches every setting the frame uses
    if (pix_frame_start_in && q.capture) begin
      d.f_left      = sel_left; // RULE22
      d.f_top       = sel_top;
      d.f_width     = sel_width;
      d.f_height    = sel_height;
      d.f_gain      = q.gain;
      d.f_offset    = offset_calc;
      d.f_wide      = q.wide;
      d.rd_units    = rd_calc;
      d.delay_units = delay_calc;
      d.col         = '0;
      d.row         = '0;
      d.timer       = '0;
      d.waiting     = 1'b1;
    end else begin
      // Raster position of the sensor stream
      if (pix_valid_in) begin
        if (q.col == SENSOR_COLS - 11'd1) begin
          d.col = '0;
          d.row = q.row + 11'd1;
        end else begin
          d.col = q.col + 11'd1;
        end
      end
      // Start delay runs from the start of readout
      if (q.waiting) begin
        d.timer = q.timer + 32'(UNITS_PER_CLK);
        if (d.timer >= q.delay_units) begin // RULE4 RULE5
          d.waiting   = 1'b0;
          d.sending   = 1'b1;
          d.tx_start  = 1'b1;
          d.remaining = 22'(q.f_width * q.f_height);
        end
      end
    end

    if (buf_push && buf_full) begin
      d.overrun = 1'b1;
    end

    // Output stage keeps data steady while the path stalls
    if (tx_ready_in) begin
      d.out_valid = 1'b0;
    end
    if (buf_pop) begin
      d.out_valid = 1'b1;
      d.out_data  = buf_data;
      d.remaining = q.remaining - 22'd1;
      if (q.remaining == 22'd1) begin
        d.sending = 1'b0;
      end
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q          <= '0;
      q.gain     <= GAIN_RST;
      q.f_gain   <= GAIN_RST;
      q.bright   <= BRIGHT_RST;
      q.width0   <= SENSOR_COLS;
      q.height0  <= SENSOR_ROWS;
      q.width1   <= SENSOR_COLS;
      q.height1  <= SENSOR_ROWS;
      q.f_width  <= SENSOR_COLS;
      q.f_height <= SENSOR_ROWS;
      q.pkts     <= PKTS_RST;
    end else if (ce_in) begin
      q <= d;
    end
  end

  // Frame buffer between readout and transmission
  iwb_frame_buf #(
    .WIDTH (PIX_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .push_in      (buf_push),
    .push_data_in (pix_out),
    .full_out     (buf_full),
    .pop_in       (buf_pop),
    .pop_data_out (buf_data),
    .empty_out    (buf_empty)
  );

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign reg_rdata_out         = q.rdata;
  assign gain_setting_code_out = q.f_gain; // RULE6
  assign tx_frame_start_out    = q.tx_start;
  assign tx_valid_out          = q.out_valid;
  assign tx_data_out           = q.out_data;

endmodule // iwb_image_ctrl

//--- pkg/iwb_pkg.sv
package iwb_pkg;

  // ***************************************************************
  // Bus and register map (word addresses)
  // ***************************************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_VIDEO  = 4'h1;
  localparam logic [3:0] REG_GAIN   = 4'h2;
  localparam logic [3:0] REG_BRIGHT = 4'h3;
  localparam logic [3:0] REG_POS0   = 4'h4;
  localparam logic [3:0] REG_SIZE0  = 4'h5;
  localparam logic [3:0] REG_POS1   = 4'h6;
  localparam logic [3:0] REG_SIZE1  = 4'h7;
  localparam logic [3:0] REG_PKTS   = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;
  localparam logic [3:0] REG_RDTIME = 4'hA;
  localparam logic [3:0] REG_DELAY  = 4'hB;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int unsigned CTRL_CAPTURE_BIT = 0;
  localparam int unsigned CTRL_WIDE_BIT    = 1;
  localparam int unsigned VID_MODE_LSB     = 0;
  localparam int unsigned VID_FMT_LSB      = 8;
  localparam int unsigned VID_FIELD_W      = 3;
  localparam int unsigned COORD_W          = 11;
  localparam int unsigned POS_LEFT_LSB     = 0;
  localparam int unsigned POS_TOP_LSB      = 16;
  localparam int unsigned SIZE_WIDTH_LSB   = 0;
  localparam int unsigned SIZE_HEIGHT_LSB  = 16;
  localparam int unsigned GAIN_W           = 10;
  localparam int unsigned BRIGHT_W         = 8;
  localparam int unsigned PKTS_W           = 16;
  localparam int unsigned STAT_OVERRUN_BIT = 0;
  localparam int unsigned STAT_WAIT_BIT    = 1;
  localparam int unsigned STAT_TX_BIT      = 2;

  // ***************************************************************
  // Settings, limits and reset values
  // ***************************************************************
  localparam logic [9:0]  GAIN_MIN       = 10'd350;
  localparam logic [9:0]  GAIN_RST       = 10'd350;
  localparam logic [7:0]  BRIGHT_RST     = 8'h00;
  localparam int unsigned BRIGHT_SHIFT   = 4;
  localparam logic [7:0]  BRIGHT_WIDE_BIAS = 8'd15;
  localparam logic [2:0]  FMT_REGION     = 3'd7;
  localparam logic [2:0]  MODE_0         = 3'd0;
  localparam logic [2:0]  MODE_1         = 3'd1;
  localparam logic [10:0] SENSOR_COLS    = 11'd1624;
  localparam logic [10:0] ROWS_MONO      = 11'd1236;
  localparam logic [10:0] ROWS_COLOR     = 11'd1234;
  localparam logic [15:0] PKTS_RST       = 16'd1;

  // ***************************************************************
  // Timing, kept in units of 10 ns so every figure is exact
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned UNIT_NS       = 10;
  localparam int unsigned ROW_TIME_NS   = 52550;
  localparam int unsigned MONO_C_NS     = 6557800;
  localparam int unsigned COLOR_C_NS    = 6610350;
  localparam int unsigned BUS_CYCLE_NS  = 125000;
  localparam int unsigned ROW_UNITS     = ROW_TIME_NS / UNIT_NS;
  localparam int unsigned MONO_C_UNITS  = MONO_C_NS / UNIT_NS;
  localparam int unsigned COLOR_C_UNITS = COLOR_C_NS / UNIT_NS;
  localparam int unsigned CYCLE_UNITS   = BUS_CYCLE_NS / UNIT_NS;
  localparam int unsigned UNITS_PER_CLK = CLK_PERIOD_NS / UNIT_NS;

endpackage

//--- verif/iwb_host_model.sv
`timescale 1ns/1ns
module iwb_host_model #(
  parameter int unsigned PIX_W = 16
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  // Transmit path
  input  wire logic             tx_valid_in,
  input  wire logic [PIX_W-1:0] tx_data_in,
  output logic                  tx_ready_out,
  // Accepted pixels
  output logic                  got_out,
  output logic [PIX_W-1:0]      got_data_out
);
  // Stall about one slot in four, a busy bus is never kinder
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) tx_ready_out <= 1'b0;
    else tx_ready_out <= ($urandom % 4) != 0;
  end
  // A pixel is taken on each edge with both high
  assign got_out      = tx_valid_in && tx_ready_out;
  assign got_data_out = tx_data_in;
endmodule // iwb_host_model

//--- verif/iwb_image_ctrl_sva.sv
`timescale 1ns/1ns
module iwb_image_ctrl_sva
  import iwb_pkg::*;
#(
  parameter int unsigned PIX_W   = 16,
  parameter int unsigned CYCLE_U = 100
) (
  // Clock and reset
  input wire logic              mclk_in,
  input wire logic              rst_n_in,
  input wire logic              ce_in,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  // Streams
  input wire logic              pix_frame_start_in,
  input wire logic [GAIN_W-1:0] gain_setting_code_out,
  input wire logic              tx_frame_start_out,
  input wire logic              tx_valid_out,
  input wire logic [PIX_W-1:0]  tx_data_out,
  input wire logic              tx_ready_in
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ****************************************
  // Cycles since the last frame start
  // ****************************************
  logic [15:0] since_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) since_q <= 16'h0;
    else if (pix_frame_start_in) since_q <= 16'h0;
    else if (since_q != 16'hFFFF) since_q <= since_q + 16'h1;
  end
  rdata_idle_a: assert property (ce_in && !reg_rd_in |=> reg_rdata_out == '0)
    else $error("read data not cleared");
  gain_rdback_a: assert property (
    ce_in && reg_wr_in && reg_addr_in == REG_GAIN &&
    reg_wdata_in[9:0] >= GAIN_MIN ##1 reg_rd_in && reg_addr_in == REG_GAIN
    |=> reg_rdata_out[9:0] == $past(reg_wdata_in[9:0], 2))
    else $error("gain readback wrong");
  gain_clamp_a: assert property (
    ce_in && reg_wr_in && reg_addr_in == REG_GAIN &&
    reg_wdata_in[9:0] < GAIN_MIN ##1 reg_rd_in && reg_addr_in == REG_GAIN
    |=> reg_rdata_out[9:0] == GAIN_MIN)
    else $error("low gain not clamped");
  bright_rdback_a: assert property (
    ce_in && reg_wr_in && reg_addr_in == REG_BRIGHT ##1
    reg_rd_in && reg_addr_in == REG_BRIGHT
    |=> reg_rdata_out[7:0] == $past(reg_wdata_in[7:0], 2))
    else $error("brightness readback wrong");
  gain_floor_a: assert property (gain_setting_code_out >= GAIN_MIN)
    else $error("gain output below unity");
  gain_latch_a: assert property (
    $changed(gain_setting_code_out) |-> $past(pix_frame_start_in))
    else $error("gain changed outside frame start");
  fs_pulse_a: assert property (
    $rose(tx_frame_start_out) |=> $fell(tx_frame_start_out))
    else $error("transmit start not one cycle");
  start_gap_a: assert property (
    $rose(tx_frame_start_out) |-> since_q >= 16'(CYCLE_U / 2))
    else $error("transmit started too early");
  tx_hold_a: assert property (
    tx_valid_out && !tx_ready_in && ce_in
    |=> tx_valid_out && $stable(tx_data_out))
    else $error("transmit data dropped while stalled");
endmodule // iwb_image_ctrl_sva
bind iwb_image_ctrl iwb_image_ctrl_sva #(.PIX_W(PIX_W), .CYCLE_U(CYCLE_U)) chk (
  .mclk_in, .rst_n_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .pix_frame_start_in, .gain_setting_code_out,
  .tx_frame_start_out, .tx_valid_out, .tx_data_out, .tx_ready_in);

//--- verif/tb.sv
`timescale 1ns/1ns
module tb;
  import iwb_pkg::*;
  typedef struct { string n; logic [31:0] v; } iwb_exp_t;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0, ce = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        wr_s = 1'b0, rd_s = 1'b0, rd_pend = 1'b0, fs = 1'b0, pv = 1'b0;
  logic [15:0] pd = 16'h0, tx_d, got_d;
  logic [9:0]  gain;
  logic        tx_fs, tx_v, tx_r, got;
  int          miscompares = 0, cmp_count = 0, cyc = 0, t0 = 0, gap = 0;
  int          l, t, b, v, pq[$];
  iwb_exp_t    rq[$], e;
  always #10 mclk_in = ~mclk_in;
  iwb_image_ctrl #(.COLOR_UNIT(1'b1), .BUF_DEPTH(16), .ROW_U(50),
    .COLOR_C_U(210), .CYCLE_U(100)) uut (
    .mclk_in, .rst_n_in, .ce_in(ce), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .pix_frame_start_in(fs), .pix_valid_in(pv), .pix_data_in(pd),
    .gain_setting_code_out(gain), .tx_frame_start_out(tx_fs),
    .tx_valid_out(tx_v), .tx_data_out(tx_d), .tx_ready_in(tx_r));
  iwb_host_model host (.mclk_in, .rst_n_in, .tx_valid_in(tx_v),
    .tx_data_in(tx_d), .tx_ready_out(tx_r), .got_out(got), .got_data_out(got_d));
  // ****************************************
  // Scoreboard
  // ****************************************
  task automatic check(input string n, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (fs) t0 <= cyc;
    if (tx_fs) gap <= cyc - t0;
    if (rd_pend) begin
      e = rq.pop_front();
      check(e.n, rdata, e.v);
    end
    rd_pend <= rd_s;
    if (got && pq.size() == 0) check("extra pixel", 32'h1, 32'h0);
    else if (got) check("pixel", {16'h0, got_d}, pq.pop_front());
  end
  // ****************************************
  // Bus and stream drivers
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk_in);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x, input string n);
    @(posedge mclk_in);
    addr <= a;
    rd_s <= 1'b1;
    rq.push_back('{n, x});
    @(posedge mclk_in);
    rd_s <= 1'b0;
  endtask
  // Write then read back with no gap
  task automatic wrrd(input logic [3:0] a, input logic [31:0] d, x,
                      input string n);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk_in);
    wr_s <= 1'b0;
    rd_s <= 1'b1;
    rq.push_back('{n, x});
    @(posedge mclk_in);
    rd_s <= 1'b0;
  endtask
  // Full raster rows; only the window is expected out, saturated
  task automatic frame(input int l, t, w, h, off, mx, input int dly);
    int d;
    @(posedge mclk_in);
    fs <= 1'b1;
    @(posedge mclk_in);
    fs <= 1'b0;
    for (int r = 0; r < t + h; r++) begin
      for (int c = 0; c < int'(SENSOR_COLS); c++) begin
        d = $urandom % (mx + 1);
        pv <= 1'b1;
        pd <= d[15:0];
        if (r >= t && c >= l && c < l + w) pq.push_back(d + off > mx ? mx : d + off);
        @(posedge mclk_in);
      end
    end
    pv <= 1'b0;
    for (int i = 0; i < 2000 && pq.size() > 0; i++) @(posedge mclk_in);
    check("drained", pq.size(), 32'h0);
    check("start gap", {31'h0, gap >= dly / 2 && gap <= dly / 2 + 4}, 32'h1);
    rd(REG_RDTIME, 32'(2 * 50 + 210), "readout time");
    rd(REG_DELAY, dly, "start delay");
  endtask
  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(32'hea71));
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(REG_GAIN, 32'(GAIN_MIN), "gain reset");
    rd(REG_BRIGHT, 32'h0, "bright reset");
    rd(REG_SIZE0, {5'h0, ROWS_COLOR, 5'h0, SENSOR_COLS}, "size0");
    rd(REG_SIZE1, {5'h0, ROWS_COLOR, 5'h0, SENSOR_COLS}, "size1");
    rd(REG_POS0, 32'h0, "pos0 reset");
    rd(4'hF, 32'h0, "unmapped");
    $display("Test reset values done");
    wrrd(REG_GAIN, 32'h15D, 32'h15E, "gain clamp");
    wrrd(REG_GAIN, 32'h3FF, 32'h3FF, "gain top");
    v = 350 + $urandom % 162;
    wrrd(REG_GAIN, v, v, "gain wide range");
    b = $urandom % 256;
    wrrd(REG_BRIGHT, b, b, "bright");
    ce <= 1'b0;
    wr(REG_BRIGHT, ~b);
    ce <= 1'b1;
    rd(REG_BRIGHT, b, "frozen");
    $display("Test settings done");
    l = 2 * ($urandom % 8);
    t = 2 * ($urandom % 2);
    wr(REG_VIDEO, 32'h700);
    wr(REG_POS0, (t << 16) | l);
    wr(REG_SIZE0, 32'h20004);
    wr(REG_PKTS, 32'h1);
    wr(REG_CTRL, 32'h1);
    frame(l, t, 4, 2, b >> 4, 255, 310);
    $display("Test narrow window done");
    l = 2 * ($urandom % 8);
    b = 16 + $urandom % 240;
    wr(REG_CTRL, 32'h2);
    wr(REG_SIZE1, 32'h20006);
    wr(REG_CTRL, 32'h3);
    wrrd(REG_SIZE1, 32'h20008, 32'h20006, "size frozen");
    wr(REG_VIDEO, 32'h701);
    wr(REG_POS1, l);
    wr(REG_BRIGHT, b);
    wr(REG_PKTS, 32'h5);
    fork
      frame(l, 0, 6, 2, b - 15, 65535, 100);
      begin
        repeat (30) @(posedge mclk_in);
        wr(REG_GAIN, 32'h1E4);
      end
    join
    check("gain latched", {22'h0, gain}, v);
    $display("Test wide window done");
    conclude();
  end
  // Runs take under 10000 cycles
  initial begin
    repeat (60000) @(posedge mclk_in);
    miscompares++;
    conclude();
  end
endmodule // tb
